// ### dv/ses_host.sv
// Bus controller model issuing decoded common commands
`timescale 1ns/1ps
`default_nettype none
module ses_host
    import ses_pkg::*;
(
    // Clock and handshake
    input  wire logic              clk,
    input  wire logic              cmd_ready,
    // Command to the device
    output var logic               cmd_valid,
    output var ses_pkg::ses_cmd_t  cmd_code,
    output var logic [7:0]         cmd_arg,
    output var logic               msg_end,
    output var logic               cmd_error
);
    initial begin
        {cmd_valid, msg_end, cmd_error, cmd_arg} = '0;
        cmd_code = SES_CMD_NONE;
    end
    // Offer on a falling edge, hold until taken; released argument is inverted
    task automatic send(input ses_cmd_t c, input logic [7:0] a, input logic last, err, output bit to);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_arg = a;
        msg_end = last;
        cmd_error = err;
        while (!cmd_ready && n < 200) begin
            @(negedge clk);
            n++;
        end
        to = !cmd_ready;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_arg <= ~a;
        @(negedge clk);
    endtask
endmodule // ses_host
`default_nettype wire

// ### dv/ses_status_chk.sv
// Assertion checker for the standard event status block
`timescale 1ns/1ps
`default_nettype none
module ses_status_chk
    import ses_pkg::*;
#(
    parameter logic [7:0] OPTION_CODE = ses_pkg::SES_OPT_NONE
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Command handshake
    input wire logic              cmd_valid,
    input wire ses_pkg::ses_cmd_t cmd_code,
    input wire logic [7:0]        cmd_arg,
    input wire logic              msg_end,
    input wire logic              cmd_ready,
    input wire logic              cmd_error,
    input wire logic              ops_pending,
    // Outputs
    input wire logic              resp_valid,
    input wire logic [7:0]        resp_data,
    input wire logic              clear_all,
    input wire logic [15:0]       esr_out,
    input wire logic [15:0]       ese_out,
    input wire logic [7:0]        stb_out
);
    logic skip_q;
    logic tk;
    // Skipped commands after an error must not trigger checks
    assign tk = cmd_valid && cmd_ready && !cmd_error && !skip_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) skip_q <= 1'b0;
        else if (cmd_valid && cmd_ready) skip_q <= (skip_q || cmd_error) && !msg_end;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    unused_bits_a: assert property (((esr_out | ese_out) & ~SES_USED_MASK) == 16'h0000)
        else $error("Unused bit set");
    ese_load_a: assert property (tk && cmd_code == SES_CMD_ESE |=> ese_out == ({8'h00, $past(cmd_arg)} & SES_USED_MASK))
        else $error("Enable mask not loaded");
    esr_read_a: assert property (tk && cmd_code == SES_CMD_ESRQ |=> resp_valid && {8'h00, resp_data} == $past(esr_out))
        else $error("Event query reply wrong");
    cls_clear_a: assert property (tk && cmd_code == SES_CMD_CLS |=> clear_all && !esr_out[0])
        else $error("Clear status missed");
    esb_sum_a: assert property (stb_out[SES_STB_ESB] == |(esr_out & ese_out))
        else $error("Summary bit wrong");
    opc_hold_a: assert property (ops_pending && !esr_out[0] |=> !esr_out[0])
        else $error("Completion bit set early");
    opc_reply_a: assert property (tk && cmd_code == SES_CMD_OPCQ && !ops_pending |=> resp_valid && resp_data == SES_ASCII_ONE)
        else $error("Completion reply wrong");
    wait_hold_a: assert property (tk && cmd_code == SES_CMD_WAI && ops_pending |=> !cmd_ready)
        else $error("Wait did not hold");
    opq_hold_a: assert property (tk && cmd_code == SES_CMD_OPCQ && ops_pending |=> !cmd_ready && !resp_valid)
        else $error("Completion query not held");
    option_a: assert property (tk && cmd_code == SES_CMD_OPTQ |=> resp_valid && resp_data == OPTION_CODE)
        else $error("Option reply wrong");
endmodule // ses_status_chk
bind ses_status ses_status_chk #(
    .OPTION_CODE (OPTION_CODE)
) chk_u (
    .clk         (clk),
    .rst         (rst),
    .cmd_valid   (cmd_valid),
    .cmd_code    (cmd_code),
    .cmd_arg     (cmd_arg),
    .msg_end     (msg_end),
    .cmd_ready   (cmd_ready),
    .cmd_error   (cmd_error),
    .ops_pending (ops_pending),
    .resp_valid  (resp_valid),
    .resp_data   (resp_data),
    .clear_all   (clear_all),
    .esr_out     (esr_out),
    .ese_out     (ese_out),
    .stb_out     (stb_out)
);
`default_nettype wire

// ### dv/tb_top.sv
// Testbench for the standard event status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ses_pkg::*;
    logic clk, rst, cmd_valid, msg_end, cmd_ready, cmd_error, ops_pending;
    logic exec_error, dev_error, empty_read, local_key, resp_valid, clear_all;
    ses_cmd_t cmd_code;
    logic [7:0] cmd_arg, stb_other, resp_data, stb_out;
    logic [15:0] esr_out, ese_out;
    int err_count = 0;
    int check_count = 0;
    ses_status dut_u (.*);
    ses_host host_u (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [23:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input ses_cmd_t c, input logic [7:0] a = 8'h00, input logic last = 1'b1, err = 1'b0);
        bit to;
        host_u.send(c, a, last, err, to);
        if (to) begin
            err_count++;
            final_report();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask
    // Holds a command against pending work, then lets the work finish
    task automatic held(input ses_cmd_t c);
        ops_pending = 1;
        fork
            cmd(c);
            begin
                repeat (4) @(negedge clk);
                check({cmd_ready, resp_valid}, 0);
                ops_pending = 0;
            end
        join
        @(negedge clk);
    endtask
    initial begin
        {rst, ops_pending, exec_error, dev_error, empty_read, local_key} = 6'h20;
        stb_other = 8'h11;
        repeat (3) @(negedge clk);
        check(esr_out | ese_out, 0);
        rst = 0;
        @(negedge clk);
        check(esr_out, 16'h0080);
        cmd(SES_CMD_ESRQ);
        check({resp_valid, resp_data, esr_out[7:0]}, 24'h018000);
        for (int n = 0; n < 8; n++) begin
            cmd(SES_CMD_ESE, 8'(1 << n));
            check(ese_out, 16'(1 << n) & 16'h00fd);
        end
        cmd(SES_CMD_ESE, 8'hff);
        cmd(SES_CMD_ESEQ);
        check({resp_valid, resp_data}, 16'h01fd);
        cmd(SES_CMD_ESE, 8'd36);
        pulse(exec_error);
        check({esr_out[7:0], stb_out}, 16'h1011);
        pulse(empty_read);
        check(stb_out, 8'h31);
        pulse(dev_error);
        pulse(local_key);
        check(esr_out, 16'h005c);
        cmd(SES_CMD_STBQ);
        check({resp_valid, resp_data}, 16'h0131);
        cmd(SES_CMD_SRE, 8'h55);
        cmd(SES_CMD_SREQ);
        check({resp_valid, resp_data}, 16'h0155);
        cmd(SES_CMD_OPTQ);
        check({resp_valid, resp_data}, 16'h0100);
        cmd(SES_CMD_CLS);
        check({clear_all, esr_out[7:0], stb_out}, 24'h010011);
        ops_pending = 1;
        cmd(SES_CMD_OPC);
        repeat (3) @(negedge clk);
        check(esr_out, 0);
        ops_pending = 0;
        repeat (2) @(negedge clk);
        check(esr_out, 16'h0001);
        ops_pending = 1;
        cmd(SES_CMD_OPC);
        cmd(SES_CMD_CLS);
        ops_pending = 0;
        repeat (2) @(negedge clk);
        check(esr_out, 0);
        held(SES_CMD_OPCQ);
        check({resp_valid, resp_data}, 16'h0131);
        held(SES_CMD_WAI);
        cmd(SES_CMD_ESE, 8'h04, 0);
        cmd(SES_CMD_NONE, 8'h00, 0, 1);
        cmd(SES_CMD_ESE, 8'hff);
        check({ese_out[7:0], esr_out[7:0] & 8'h20}, 16'h0420);
        cmd(SES_CMD_ESE, 8'h01);
        check(ese_out, 16'h0001);
        final_report();
    end
endmodule // tb_top
`default_nettype wire

// ### rtl/ses_pkg.sv
// Package: constants for the standard event status reporting block
package ses_pkg;
    localparam int unsigned SES_REG_W     = 16;
    localparam int unsigned SES_EVT_W     = 8;
    // Event bit positions in the event status register
    localparam int unsigned SES_BIT_OPC   = 0;
    localparam int unsigned SES_BIT_QYE   = 2;
    localparam int unsigned SES_BIT_DDE   = 3;
    localparam int unsigned SES_BIT_EXE   = 4;
    localparam int unsigned SES_BIT_CME   = 5;
    localparam int unsigned SES_BIT_URQ   = 6;
    localparam int unsigned SES_BIT_PON   = 7;
    // Bits that may ever be set or enabled
    localparam logic [15:0] SES_USED_MASK = 16'h00fd;
    // Summary bit position in the status byte
    localparam int unsigned SES_STB_ESB   = 5;
    // Reset values
    localparam logic [15:0] SES_ESR_RST   = 16'h0000;
    localparam logic [15:0] SES_ESE_RST   = 16'h0000;
    localparam logic [7:0]  SES_SRE_RST   = 8'h00;
    // Reply for the operation complete query: ASCII "1"
    localparam logic [7:0]  SES_ASCII_ONE = 8'h31;
    // Default option code, 0 means none fitted
    localparam logic [7:0]  SES_OPT_NONE  = 8'h00;

    // Decoded common commands
    typedef enum logic [3:0] {
        SES_CMD_NONE = 4'h0,
        SES_CMD_CLS  = 4'h1,
        SES_CMD_ESE  = 4'h2,
        SES_CMD_ESEQ = 4'h3,
        SES_CMD_ESRQ = 4'h4,
        SES_CMD_OPC  = 4'h5,
        SES_CMD_OPCQ = 4'h6,
        SES_CMD_OPTQ = 4'h7,
        SES_CMD_SRE  = 4'h8,
        SES_CMD_SREQ = 4'h9,
        SES_CMD_STBQ = 4'ha,
        SES_CMD_WAI  = 4'hb
    } ses_cmd_t;

    // Operation complete tracker states
    typedef enum logic [1:0] {
        SES_TRK_IDLE = 2'b01,
        SES_TRK_ACT  = 2'b10
    } ses_trk_t;
endpackage

// ### rtl/ses_status.sv
// Standard event status register, enable mask, trackers and status byte
// Summary of operation
// - Clear-status zeroes all event registers and empties the error queue.
// - Clear-status returns both operation-complete trackers to idle.
// - Enable command loads its value into the event enable mask.
// - Bit n weighs 2^n; host sends the sum of wanted weights.
// - Event enable mask is zero after power-up.
// - Summary bit sets only from an event whose enable bit is one.
// - Event status query returns the register, then clears it.
// - Event status register is zero in reset and after clear-status; bit 7 sets at the first clock after reset.
// - Bit 0 sets once pending operations finish; tied to completion tracking.
// - Bit 1 and bits 8 to 15 never set; always read zero.
// - Bit 2 sets when the host reads an empty output queue.
// - Bit 3 sets on an internal device-dependent failure.
// - Bit 4 sets on an execution error of an accepted command.
// - Bit 5 sets on a command error, unless its message is already being ignored.
// - Bit 6 sets when the front-panel local key is pressed.
// - Bit 7 sets after power restored since the last read; read clears it.
// - Operation-complete command sets bit 0 only after all pending work ends.
// - Operation-complete query queues ASCII 1 after pending operations finish.
// - Service request enable command loads mask; its query returns it.
// - Status byte query returns the status byte with the summary bit.
// - Wait-to-continue holds later commands until earlier ones complete.
// - Commands run in order; after an invalid one the rest of its message is ignored.
`timescale 1ns/1ps
`default_nettype none
module ses_status
    import ses_pkg::*;
#(
    parameter logic [7:0] OPTION_CODE = ses_pkg::SES_OPT_NONE
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Decoded command from the parser
    input  wire logic              cmd_valid,
    input  wire ses_pkg::ses_cmd_t cmd_code,
    input  wire logic [7:0]        cmd_arg,
    input  wire logic              msg_end,
    output logic                   cmd_ready,
    // Error and event sources
    input  wire logic              cmd_error,
    input  wire logic              exec_error,
    input  wire logic              dev_error,
    input  wire logic              empty_read,
    input  wire logic              local_key,
    input  wire logic              ops_pending,
    // Status byte sources from other registers
    input  wire logic [7:0]        stb_other,
    // Response to the output queue
    output logic                   resp_valid,
    output logic [7:0]             resp_data,
    // Clear pulse for other event registers and error queue
    output logic                   clear_all,
    // Register views
    output logic [15:0]            esr_out,
    output logic [15:0]            ese_out,
    output logic [7:0]             stb_out
);
    import ses_pkg::*;

    logic [15:0] esr_reg, esr_next;
    logic [15:0] ese_reg;
    logic [7:0]  sre_reg;
    logic        pon_seen_reg;
    logic        skip_reg;
    logic        wait_reg;
    ses_trk_t    opc_trk_reg;
    ses_trk_t    opq_trk_reg;
    logic        resp_valid_reg;
    logic [7:0]  resp_data_reg;
    logic        clear_reg;
    logic [7:0]  stb_reg;
    logic        cmd_ready_reg;
    ses_trk_t    opc_trk_next;
    ses_trk_t    opq_trk_next;

    // Command accept: a bad command drops the rest of its message
    wire take     = cmd_valid && cmd_ready;
    wire run      = take && !skip_reg && !cmd_error;
    wire is_cls   = run && (cmd_code == SES_CMD_CLS);
    wire is_ese   = run && (cmd_code == SES_CMD_ESE);
    wire is_eseq  = run && (cmd_code == SES_CMD_ESEQ);
    wire is_esrq  = run && (cmd_code == SES_CMD_ESRQ);
    wire is_opc   = run && (cmd_code == SES_CMD_OPC);
    wire is_opcq  = run && (cmd_code == SES_CMD_OPCQ);
    wire is_optq  = run && (cmd_code == SES_CMD_OPTQ);
    wire is_sre   = run && (cmd_code == SES_CMD_SRE);
    wire is_sreq  = run && (cmd_code == SES_CMD_SREQ);
    wire is_stbq  = run && (cmd_code == SES_CMD_STBQ);
    wire is_wai   = run && (cmd_code == SES_CMD_WAI);
    wire cmd_err  = take && !skip_reg && cmd_error;

    // Completion both trackers can see this cycle; clear-status discards it
    wire opc_done = (opc_trk_reg == SES_TRK_ACT) && !ops_pending && !is_cls;
    wire opq_done = (opq_trk_reg == SES_TRK_ACT) && !ops_pending && !is_cls;
    wire opc_now  = is_opc && !ops_pending;

    // Wait hold lasts only while earlier work is still pending
    wire wait_next  = (is_wai || wait_reg) && ops_pending;
    // Hold later commands during a wait or a held completion query
    wire ready_next = !wait_next && (opq_trk_next == SES_TRK_IDLE);

    // New events this cycle
    logic [15:0] evt_set;
    always_comb begin
        evt_set = '0;
        evt_set[SES_BIT_OPC] = opc_done || opc_now;
        evt_set[SES_BIT_QYE] = empty_read;
        evt_set[SES_BIT_DDE] = dev_error;
        evt_set[SES_BIT_EXE] = exec_error;
        evt_set[SES_BIT_CME] = cmd_err;
        evt_set[SES_BIT_URQ] = local_key;
        evt_set[SES_BIT_PON] = pon_seen_reg;
        evt_set = evt_set & SES_USED_MASK;
    end

    // Read-clear and clear-status first; set wins over clear
    always_comb begin
        esr_next = esr_reg;
        if (is_cls) begin
            esr_next = SES_ESR_RST;
        end
        if (is_esrq) begin
            esr_next = SES_ESR_RST;
        end
        esr_next = esr_next | evt_set;
    end

    // Enable mask next value, so a new mask reaches the summary at once
    wire [15:0] ese_next = is_ese ? ({8'h00, cmd_arg} & SES_USED_MASK) : ese_reg;

    // Summary bit from masked events, rebuilt every cycle
    wire esb_next = |(esr_next & ese_next);
    logic [7:0] stb_next;
    always_comb begin
        stb_next = stb_other;
        stb_next[SES_STB_ESB] = esb_next;
    end

    // Response source selection
    wire [7:0] resp_next = is_eseq ? ese_reg[7:0] :
                           is_esrq ? esr_reg[7:0] :
                           is_sreq ? sre_reg :
                           is_stbq ? stb_reg :
                           is_optq ? OPTION_CODE :
                           SES_ASCII_ONE;
    // Direct queries answer at once, a held completion query when work ends
    wire resp_fire = is_eseq || is_esrq || is_sreq || is_stbq || is_optq ||
                     (is_opcq && !ops_pending) ||
                     opq_done;

    // Power-on flag is high only in the first cycle after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pon_seen_reg <= 1'b1;
        end else begin
            pon_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            esr_reg <= SES_ESR_RST;
        end else begin
            esr_reg <= esr_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ese_reg <= SES_ESE_RST;
        end else begin
            ese_reg <= ese_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sre_reg <= SES_SRE_RST;
        end else if (is_sre) begin
            sre_reg <= cmd_arg;
        end
    end

    // Operation complete trackers; clear-status forces both idle
    always_comb begin
        opc_trk_next = opc_trk_reg;
        unique case (opc_trk_reg)
            SES_TRK_IDLE: begin
                if (is_opc && ops_pending) begin
                    opc_trk_next = SES_TRK_ACT;
                end
            end
            SES_TRK_ACT: begin
                if (!ops_pending) begin
                    opc_trk_next = SES_TRK_IDLE;
                end
            end
        endcase
        if (is_cls) begin
            opc_trk_next = SES_TRK_IDLE;
        end
    end

    always_comb begin
        opq_trk_next = opq_trk_reg;
        unique case (opq_trk_reg)
            SES_TRK_IDLE: begin
                if (is_opcq && ops_pending) begin
                    opq_trk_next = SES_TRK_ACT;
                end
            end
            SES_TRK_ACT: begin
                if (!ops_pending) begin
                    opq_trk_next = SES_TRK_IDLE;
                end
            end
        endcase
        if (is_cls) begin
            opq_trk_next = SES_TRK_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opc_trk_reg <= SES_TRK_IDLE;
        end else begin
            opc_trk_reg <= opc_trk_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opq_trk_reg <= SES_TRK_IDLE;
        end else begin
            opq_trk_reg <= opq_trk_next;
        end
    end

    // A bad command drops the rest of its message
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skip_reg <= 1'b0;
        end else if (take && msg_end) begin
            skip_reg <= 1'b0;
        end else if (cmd_err) begin
            skip_reg <= 1'b1;
        end
    end

    // Wait flag never outlives the work it waits for
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= wait_next;
        end
    end

    // Response byte holds until the next reply
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_valid_reg <= 1'b0;
            resp_data_reg  <= 8'h00;
        end else begin
            resp_valid_reg <= resp_fire;
            if (resp_fire) begin
                resp_data_reg <= resp_next;
            end
        end
    end

    // Clear pulse for the other event registers and error queue
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= is_cls;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stb_reg <= 8'h00;
        end else begin
            stb_reg <= stb_next;
        end
    end

    // Ready is a flop; it comes back one cycle after pending work ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ready_reg <= 1'b1;
        end else begin
            cmd_ready_reg <= ready_next;
        end
    end

    assign cmd_ready  = cmd_ready_reg;
    assign resp_valid = resp_valid_reg;
    assign resp_data  = resp_data_reg;
    assign clear_all  = clear_reg;
    assign esr_out    = esr_reg;
    assign ese_out    = ese_reg;
    assign stb_out    = stb_reg;
endmodule // ses_status
`default_nettype wire
